// *** mapopt_pkg.sv ***
// Package: offsets, fields, resets and encodings of the option register bank
package mapopt_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_SYSTEM_OPTION_CONTROL = 8'h13;
   localparam logic [7:0] OFS_RESERVED_TEST_ZERO    = 8'h14;
   localparam logic [7:0] OFS_RESERVED_TEST_ONE     = 8'h17;
   localparam logic [7:0] OFS_MEMORY_SPACE_SIZE_0   = 8'h1c;
   localparam logic [7:0] OFS_RAM_POSITION          = 8'h10;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int STRETCH_HI   = 3;
   localparam int STRETCH_LO   = 2;
   localparam int HIDE_BIT     = 1;
   localparam int PMEM_EN_BIT  = 0;
   localparam int REGSZ_BIT    = 7;
   localparam int EEPSZ_HI     = 5;
   localparam int EEPSZ_LO     = 4;
   localparam int RAMSZ_HI     = 2;
   localparam int RAMSZ_LO     = 0;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] STRETCH_RESET  = 2'h3;
   localparam logic       HIDE_RESET     = 1'b0;
   localparam logic       PMEM_EN_SINGLE = 1'b1;
   localparam logic       PMEM_EN_TEST   = 1'b0;
   localparam logic [7:0] RAM_POSITION_RESET = 8'h09;
   localparam logic [7:0] TEST_READ_VALUE    = 8'h00;
   // ---------------------------------------------------------------
   // Operating modes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_SPECIAL_SINGLE,
      MODE_EMULATION,
      MODE_SPECIAL_TEST,
      MODE_SPECIAL_PERIPHERAL,
      MODE_NORMAL_SINGLE,
      MODE_NORMAL_EXPANDED,
      MODE_PERIPHERAL,
      MODE_EXPANDED_NARROW
   } op_mode_t;
endpackage : mapopt_pkg

// *** write_once_field.sv ***
// Module: one write-once-or-anytime register field
`timescale 1ns/1ps
`default_nettype none
module write_once_field #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Control
   input  wire logic [W-1:0] reset_val_i,
   input  wire logic         special_i,
   input  wire logic         wr_i,
   input  wire logic [W-1:0] wdata_i,
   // State
   output logic      [W-1:0] value_o
);
   logic [W-1:0] val_q;
   logic [W-1:0] val_d;
   logic         used_q;
   logic         used_d;

   always_comb begin
      val_d  = val_q;
      used_d = used_q;
      if (wr_i && (special_i || !used_q)) begin
         val_d  = wdata_i;
         used_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         val_q  <= reset_val_i;
         used_q <= 1'b0;
      end else begin
         val_q  <= val_d;
         used_q <= used_d;
      end
   end

   assign value_o = val_q;
endmodule : write_once_field
`default_nettype wire

// *** mode_sync.sv ***
// Module: three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module mode_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Pins and settled value
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] out_d;

   always_comb begin
      out_d = out_q;
      if (s2_q == s3_q) begin
         out_d = s3_q;
      end
   end

   // Pins settle while reset is held, so the boot load sees the real mode
   always_ff @(posedge clk_i) begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (!rst_n_i) begin
         out_q <= s3_q;
      end else begin
         out_q <= out_d;
      end
   end

   assign sync_o = out_q;
endmodule : mode_sync
`default_nettype wire

// *** memory_map_option_registers.sv ***
// Module: memory-map option registers, size switches and map controls
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RQ1) A write to the option register takes effect one cycle later; the map control outputs follow two cycles after the write.
// (RQ2) Bits 3:2 of the option register set the external access stretch.
// (RQ3) Stretch codes 0 to 3 add 0 to 3 E-clock cycles.
// (RQ4) In single-chip and peripheral modes the stretch has no effect.
// (RQ5) Option fields take one write in normal and emulation, any in special.
// (RQ6) Hide bit set blocks direct lower-half program access, not the window.
// (RQ7) Enable bit places program memory in the map when 1, removes it when 0.
// (RQ8) Reset: stretch 11, hide 0, enable by mode or integration value.
// (RQ9) Test locations 0x14 and 0x17 read anytime and ignore writes.
// (RQ10) Size register reads the integration switches and ignores writes.
// (RQ11) Size bit 7 reads 0 for 1K and 1 for 2K register space.
// (RQ12) Size bits 5:4 report 0K, 2K, 4K or 8K bytes of EEPROM.
// (RQ13) RAM code 000 is 2K in a 2K region, position bits 15:11, base 0x0800.
// (RQ14) Code 001 is 4K at bits 15:12 base 0; 010 is 6K in 8K, base 0.
// (RQ15) RAM placement in its region follows the high-align setting.
// (RQ16) RAM reset bases follow the position register reset value 0x09.
// (RQ17) Unused option and size bits read zero and ignore writes.
module memory_map_option_registers
   import mapopt_pkg::*;
#(
   parameter logic       PMEM_EN_EXPANDED = 1'b1,
   parameter logic       REG_SPACE_2K     = 1'b1,
   parameter logic [1:0] EEPROM_SIZE_CODE = 2'h1,
   parameter logic [2:0] RAM_SIZE_CODE    = 3'h0
) (
   // Clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_N_I,
   // Register port
   input  wire logic [7:0]  ADDR_I,
   input  wire logic [7:0]  WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output logic      [7:0]  RDATA_O,
   // Operating mode pins
   input  wire logic [2:0]  MODE_I,
   // Map lookup from the bus decoder
   input  wire logic [15:0] MAP_ADDR_I,
   input  wire logic        MAP_VIA_WINDOW_I,
   input  wire logic        EXT_ACCESS_I,
   // Map controls
   output logic [1:0]       STRETCH_CYCLES_O,
   output logic             PMEM_SELECT_O,
   output logic             RAM_SELECT_O,
   output logic             PMEM_ENABLED_O,
   output logic             LOWER_HIDDEN_O
);
   import mapopt_pkg::*;

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   logic [2:0] mode_s;
   op_mode_t   mode;
   logic       special, quiet_mode;
   logic       pmem_reset;

   mode_sync #(.W(3)) u_mode_sync (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RST_N_I),
      .async_i (MODE_I),
      .sync_o  (mode_s)
   );

   always_comb begin
      mode       = op_mode_t'(mode_s);
      special    = (mode == MODE_SPECIAL_SINGLE) || (mode == MODE_SPECIAL_TEST)
                   || (mode == MODE_SPECIAL_PERIPHERAL);
      quiet_mode = (mode == MODE_SPECIAL_SINGLE) || (mode == MODE_NORMAL_SINGLE)
                   || (mode == MODE_PERIPHERAL)
                   || (mode == MODE_SPECIAL_PERIPHERAL);
      case (mode)
         MODE_SPECIAL_TEST:    pmem_reset = PMEM_EN_TEST;  // RQ8
         MODE_EMULATION,
         MODE_NORMAL_EXPANDED,
         MODE_EXPANDED_NARROW: pmem_reset = PMEM_EN_EXPANDED;  // RQ8
         default:              pmem_reset = PMEM_EN_SINGLE;  // RQ8
      endcase
   end

   // ---------------------------------------------------------------
   // Option fields
   // ---------------------------------------------------------------
   logic       opt_wr;
   logic [1:0] stretch;
   logic       hide, pmem_en;

   assign opt_wr = WR_I && (ADDR_I == OFS_SYSTEM_OPTION_CONTROL);

   write_once_field #(.W(2)) u_stretch (  // RQ5
      .clk_i       (SYS_CLK_I),
      .rst_n_i     (RST_N_I),
      .reset_val_i (STRETCH_RESET),  // RQ8
      .special_i   (special),
      .wr_i        (opt_wr),
      .wdata_i     (WDATA_I[STRETCH_HI:STRETCH_LO]),  // RQ2
      .value_o     (stretch)
   );

   write_once_field #(.W(1)) u_hide (  // RQ5
      .clk_i       (SYS_CLK_I),
      .rst_n_i     (RST_N_I),
      .reset_val_i (HIDE_RESET),  // RQ8
      .special_i   (special),
      .wr_i        (opt_wr),
      .wdata_i     (WDATA_I[HIDE_BIT]),
      .value_o     (hide)
   );

   // Enable reset value depends on the mode, caught after release
   logic pmem_wr, pmem_val_q, pmem_val_d, pmem_used_q, pmem_used_d;
   logic boot_q, boot_d;

   always_comb begin
      pmem_val_d  = pmem_val_q;
      pmem_used_d = pmem_used_q;
      boot_d      = 1'b0;
      pmem_wr     = opt_wr && (special || !pmem_used_q);  // RQ5
      if (boot_q) begin
         pmem_val_d = pmem_reset;  // RQ8
      end
      if (pmem_wr) begin
         pmem_val_d  = WDATA_I[PMEM_EN_BIT];
         pmem_used_d = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // RAM position, kept at its reset value here
   // ---------------------------------------------------------------
   logic [7:0] ram_pos;
   logic       ram_align_high;
   assign ram_pos        = RAM_POSITION_RESET;  // RQ16
   assign ram_align_high = ram_pos[0];

   // ---------------------------------------------------------------
   // Read data and map decode
   // ---------------------------------------------------------------
   logic [7:0]  rdata_d, rdata_q;
   logic [7:0]  size_word;
   logic [1:0]  stretch_d, stretch_q;
   logic        pmem_sel_d, pmem_sel_q, ram_sel_d, ram_sel_q;
   logic [15:0] ram_mask, ram_base, ram_off;
   logic [15:0] ram_size, ram_region;

   always_comb begin
      size_word            = 8'h00;  // RQ17
      size_word[REGSZ_BIT] = REG_SPACE_2K;  // RQ11
      size_word[EEPSZ_HI:EEPSZ_LO] = EEPROM_SIZE_CODE;  // RQ12
      size_word[RAMSZ_HI:RAMSZ_LO] = RAM_SIZE_CODE;  // RQ10
      rdata_d = 8'h00;
      if (RD_I) begin
         if (ADDR_I == OFS_SYSTEM_OPTION_CONTROL) begin
            rdata_d = {4'h0, stretch, hide, pmem_val_q};  // RQ17
         end else if (ADDR_I == OFS_RESERVED_TEST_ZERO) begin
            rdata_d = TEST_READ_VALUE;  // RQ9
         end else if (ADDR_I == OFS_RESERVED_TEST_ONE) begin
            rdata_d = TEST_READ_VALUE;  // RQ9
         end else if (ADDR_I == OFS_MEMORY_SPACE_SIZE_0) begin
            rdata_d = size_word;  // RQ10
         end else begin
            rdata_d = 8'h00;
         end
      end
      // Region mask by size code
      case (RAM_SIZE_CODE)
         3'h0: begin ram_size = 16'h0800; ram_region = 16'h0800; end  // RQ13
         3'h1: begin ram_size = 16'h1000; ram_region = 16'h1000; end  // RQ14
         3'h2: begin ram_size = 16'h1800; ram_region = 16'h2000; end  // RQ14
         3'h3: begin ram_size = 16'h2000; ram_region = 16'h2000; end
         3'h4: begin ram_size = 16'h2800; ram_region = 16'h4000; end
         3'h5: begin ram_size = 16'h3000; ram_region = 16'h4000; end
         3'h6: begin ram_size = 16'h3800; ram_region = 16'h4000; end
         default: begin ram_size = 16'h4000; ram_region = 16'h4000; end
      endcase
      ram_mask = ~(ram_region - 16'h0001);
      ram_base = {ram_pos[7:3], 11'h000} & ram_mask;  // RQ13
      ram_off  = MAP_ADDR_I - ram_base;
      // Allocated part sits at the low or high end of the region
      if (ram_align_high) begin  // RQ15
         ram_sel_d = ((MAP_ADDR_I & ram_mask) == ram_base)
                     && (ram_off >= (ram_region - ram_size));
      end else begin
         ram_sel_d = ((MAP_ADDR_I & ram_mask) == ram_base)
                     && (ram_off < ram_size);
      end
      // Program memory when enabled: upper half and window always, lower half unless hidden
      pmem_sel_d = pmem_val_q  // RQ7
                   && (MAP_VIA_WINDOW_I || MAP_ADDR_I[15] || !hide);  // RQ6
      stretch_d = (EXT_ACCESS_I && !quiet_mode) ? stretch : 2'h0;  // RQ4 RQ3
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         pmem_val_q  <= PMEM_EN_SINGLE;
         pmem_used_q <= 1'b0;
         boot_q      <= 1'b1;
         rdata_q     <= 8'h00;
         stretch_q   <= 2'h0;
         pmem_sel_q  <= 1'b0;
         ram_sel_q   <= 1'b0;
      end else begin
         pmem_val_q  <= pmem_val_d;  // RQ1
         pmem_used_q <= pmem_used_d;
         boot_q      <= boot_d;
         rdata_q     <= rdata_d;
         stretch_q   <= stretch_d;
         pmem_sel_q  <= pmem_sel_d;
         ram_sel_q   <= ram_sel_d;
      end
   end

   logic hide_q, pmem_en_q;
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         hide_q    <= 1'b0;
         pmem_en_q <= 1'b0;
      end else begin
         hide_q    <= hide;
         pmem_en_q <= pmem_val_q;
      end
   end
   assign pmem_en = pmem_en_q;

   assign RDATA_O          = rdata_q;
   assign STRETCH_CYCLES_O = stretch_q;
   assign PMEM_SELECT_O    = pmem_sel_q;
   assign RAM_SELECT_O     = ram_sel_q;
   assign PMEM_ENABLED_O   = pmem_en;
   assign LOWER_HIDDEN_O   = hide_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_write_delay: assert property (  // RQ1
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      pmem_wr ##1 1'b1 |=> PMEM_ENABLED_O == $past(WDATA_I[0], 2))
      else $error("enable write not seen two cycles later");
   a_write_hide: assert property (  // RQ1
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      (opt_wr && special) ##1 1'b1
      |=> LOWER_HIDDEN_O == $past(WDATA_I[HIDE_BIT], 2))
      else $error("hide write not seen two cycles later");
   a_stretch_quiet: assert property (  // RQ4
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      quiet_mode |=> STRETCH_CYCLES_O == 2'h0)
      else $error("stretch active in quiet mode");
   a_stretch_value: assert property (  // RQ2
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      EXT_ACCESS_I && !quiet_mode |=> STRETCH_CYCLES_O == $past(stretch))
      else $error("stretch count mismatch");
   a_stretch_internal: assert property (  // RQ2
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !EXT_ACCESS_I |=> STRETCH_CYCLES_O == 2'h0)
      else $error("stretch on internal access");
   a_once_locked: assert property (  // RQ5
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      opt_wr && !special && pmem_used_q |=> $stable(pmem_val_q))
      else $error("second write accepted in normal mode");
   a_reset_fields: assert property (  // RQ8
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $rose(RST_N_I) |-> !hide && stretch == STRETCH_RESET)
      else $error("option fields wrong after reset");
   a_hide_block: assert property (  // RQ6
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      hide && !MAP_ADDR_I[15] && !MAP_VIA_WINDOW_I |=> !PMEM_SELECT_O)
      else $error("hidden lower half selected");
   a_pmem_upper: assert property (  // RQ6
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      pmem_val_q && MAP_ADDR_I[15] |=> PMEM_SELECT_O)
      else $error("upper program half not selected");
   a_pmem_off: assert property (  // RQ7
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !pmem_val_q |=> !PMEM_SELECT_O)
      else $error("program memory selected while removed");
   a_ram_code0: assert property (  // RQ13
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      RAM_SIZE_CODE == 3'h0
      |=> RAM_SELECT_O
         == ($past(MAP_ADDR_I[15:11]) == RAM_POSITION_RESET[7:3]))
      else $error("ram select outside its 2K region");
   a_size_read: assert property (  // RQ10
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      RD_I && ADDR_I == OFS_MEMORY_SPACE_SIZE_0 |=> RDATA_O == size_word)
      else $error("size register read wrong");
   a_test_zero: assert property (  // RQ9
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      RD_I && ADDR_I == OFS_RESERVED_TEST_ZERO |=> RDATA_O == TEST_READ_VALUE)
      else $error("first test location read wrong");
   a_test_read: assert property (  // RQ9
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      RD_I && ADDR_I == OFS_RESERVED_TEST_ONE |=> RDATA_O == 8'h00)
      else $error("test location read nonzero");
   a_opt_upper: assert property (  // RQ17
      @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      RD_I && ADDR_I == OFS_SYSTEM_OPTION_CONTROL |=> RDATA_O[7:4] == 4'h0)
      else $error("option upper bits nonzero");
endmodule : memory_map_option_registers
`default_nettype wire

// *** cpu_bus_model.sv ***
// Partner model: CPU core master on the register port
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
   // Clock
   input  wire logic       clk_i,
   // Register port
   input  wire logic [7:0] rdata_i,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o
);
   initial begin
      addr_o  = 8'h00;
      wdata_o = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   // ---------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_o    <= 1'b1;
      addr_o  <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      wdata_o <= ~d;
   endtask : write_reg

   // Data stand only in the cycle after the strobe
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      rd_o   <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      addr_o <= ~a;
      @(posedge clk_i);
      d = rdata_i;
   endtask : read_reg
endmodule : cpu_bus_model
`default_nettype wire

// *** memory_map_option_registers_tb_top.sv ***
// Testbench: option register bank against its register and map rules
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   errors++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module memory_map_option_registers_tb_top;
   import mapopt_pkg::*;
   localparam logic       EXP_EN = 1'b0;
   localparam logic [1:0] EEP    = 2'h2;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr, wdata, rdata;
   logic        wr, rd;
   logic [2:0]  mode = 3'h0;
   logic [15:0] map_addr = 16'h0000;
   logic        via_win = 1'b0;
   logic        ext = 1'b0;
   logic [1:0]  stretch;
   logic        pmem_sel, ram_sel, pmem_en, hidden;
   int          errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   logic [7:0]  d;

   always #5 clk = ~clk;

   memory_map_option_registers #(.PMEM_EN_EXPANDED(EXP_EN),
      .REG_SPACE_2K(1'b1), .EEPROM_SIZE_CODE(EEP), .RAM_SIZE_CODE(3'h0))
   i_memory_map_option_registers (.SYS_CLK_I(clk), .RST_N_I(rst_n),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .MODE_I(mode), .MAP_ADDR_I(map_addr),
      .MAP_VIA_WINDOW_I(via_win), .EXT_ACCESS_I(ext),
      .STRETCH_CYCLES_O(stretch), .PMEM_SELECT_O(pmem_sel),
      .RAM_SELECT_O(ram_sel), .PMEM_ENABLED_O(pmem_en),
      .LOWER_HIDDEN_O(hidden));

   cpu_bus_model i_cpu_bus_model (.clk_i(clk), .rdata_i(rdata),
      .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic end_sim();
      if (errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         end_sim();
      end
   end

   task automatic do_reset(input logic [2:0] m);
      @(posedge clk);
      rst_n <= 1'b0;
      mode  <= m;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : do_reset

   task automatic look(input logic [15:0] a, input logic w, input logic x);
      @(posedge clk);
      map_addr <= a;
      via_win  <= w;
      ext      <= x;
      @(posedge clk);
      #1;
   endtask : look

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_values();
      logic en;
      for (int m = 0; m < 8; m++) begin
         en = (m == 2) ? 1'b0 : (m inside {1, 5, 7}) ? EXP_EN : 1'b1;
         do_reset(3'(m));
         i_cpu_bus_model.read_reg(OFS_SYSTEM_OPTION_CONTROL, d);
         `CHK("option reset", {7'h06, en}, d)
         `CHK("enable out", en, pmem_en)
         `CHK("hide out", 1'b0, hidden)
      end
   endtask : t_reset_values

   task automatic t_write_once();
      do_reset(3'h5);
      i_cpu_bus_model.write_reg(OFS_SYSTEM_OPTION_CONTROL, 8'hf4);
      i_cpu_bus_model.write_reg(OFS_SYSTEM_OPTION_CONTROL, 8'h0b);
      i_cpu_bus_model.read_reg(OFS_SYSTEM_OPTION_CONTROL, d);
      `CHK("locked option", 8'h04, d)
      do_reset(3'h2);
      i_cpu_bus_model.write_reg(OFS_SYSTEM_OPTION_CONTROL, 8'h03);
      #1;
      `CHK("enable early", 1'b0, pmem_en)
      `CHK("hide early", 1'b0, hidden)
      @(posedge clk);
      #1;
      `CHK("enable late", 1'b1, pmem_en)
      `CHK("hide late", 1'b1, hidden)
      i_cpu_bus_model.write_reg(OFS_SYSTEM_OPTION_CONTROL, 8'hfa);
      i_cpu_bus_model.read_reg(OFS_SYSTEM_OPTION_CONTROL, d);
      `CHK("special rewrite", 8'h0a, d)
   endtask : t_write_once

   task automatic t_stretch();
      for (int c = 0; c < 4; c++) begin
         i_cpu_bus_model.write_reg(OFS_SYSTEM_OPTION_CONTROL,
                                   {4'h0, 2'(c), 2'h1});
         look(16'hc000, 1'b0, 1'b1);
         `CHK("stretch", 2'(c), stretch)
      end
      look(16'hc000, 1'b0, 1'b0);
      `CHK("internal stretch", 2'h0, stretch)
      do_reset(3'h4);
      look(16'hc000, 1'b0, 1'b1);
      `CHK("quiet stretch", 2'h0, stretch)
   endtask : t_stretch

   task automatic t_map();
      do_reset(3'h2);
      i_cpu_bus_model.write_reg(OFS_SYSTEM_OPTION_CONTROL, 8'h03);
      look(16'h4000, 1'b0, 1'b0);
      `CHK("hidden direct", 1'b0, pmem_sel)
      look(16'h8000, 1'b1, 1'b0);
      `CHK("hidden window", 1'b1, pmem_sel)
      i_cpu_bus_model.write_reg(OFS_SYSTEM_OPTION_CONTROL, 8'h01);
      look(16'h4000, 1'b0, 1'b0);
      `CHK("shown direct", 1'b1, pmem_sel)
      i_cpu_bus_model.write_reg(OFS_SYSTEM_OPTION_CONTROL, 8'h00);
      look(16'h8000, 1'b1, 1'b0);
      `CHK("memory removed", 1'b0, pmem_sel)
      look(16'h0900, 1'b0, 1'b0);
      `CHK("ram inside", 1'b1, ram_sel)
      look(16'h1000, 1'b0, 1'b0);
      `CHK("ram above", 1'b0, ram_sel)
      look(16'h07ff, 1'b0, 1'b0);
      `CHK("ram below", 1'b0, ram_sel)
   endtask : t_map

   task automatic t_read_only();
      logic [7:0] a [4] = '{OFS_RESERVED_TEST_ZERO, OFS_RESERVED_TEST_ONE,
                            OFS_MEMORY_SPACE_SIZE_0, 8'h20};
      logic [7:0] e [4] = '{TEST_READ_VALUE, TEST_READ_VALUE,
                            {1'b1, 1'b0, EEP, 4'h0}, 8'h00};
      for (int i = 0; i < 4; i++) begin
         i_cpu_bus_model.write_reg(a[i], 8'hff);
         i_cpu_bus_model.read_reg(a[i], d);
         `CHK("read only", e[i], d)
         #1;
         `CHK("data after", 8'h00, rdata)
      end
      i_cpu_bus_model.read_reg(OFS_SYSTEM_OPTION_CONTROL, d);
      `CHK("option intact", {4'h0, STRETCH_RESET, HIDE_RESET, PMEM_EN_TEST}, d)
   endtask : t_read_only

   initial begin
      t_reset_values();
      t_write_once();
      t_stretch();
      t_map();
      do_reset(3'h2);
      t_read_only();
      end_sim();
   end
endmodule : memory_map_option_registers_tb_top
`default_nettype wire
